//--- include/latch_ctrl_pkg.sv
package latch_ctrl_pkg;

	// Register byte addresses, low address bits only
	localparam int ADDR_BITS = 12;
	localparam logic [11:0] ADDR_PRIMARY = 12'h000;
	localparam logic [11:0] ADDR_SOURCES = 12'h004;

	// Fields of latch_control_primary
	localparam int PRI_ENABLE = 7;
	localparam int PRI_CODE_LSB = 4;
	localparam int PRI_TRUE_OE = 3;
	localparam int PRI_INV_OE = 2;
	localparam int PRI_FW_SET = 1;
	localparam int PRI_FW_RESET = 0;

	// Fields of latch_source_enables
	localparam int SRC_PIN_SET = 7;
	localparam int SRC_CLOCK_SET = 6;
	localparam int SRC_COMP2_SET = 5;
	localparam int SRC_COMP1_SET = 4;
	localparam int SRC_PIN_RESET = 3;
	localparam int SRC_CLOCK_RESET = 2;
	localparam int SRC_COMP2_RESET = 1;
	localparam int SRC_COMP1_RESET = 0;

	// Reset values
	localparam logic [7:0] PRIMARY_RESET = 8'h00;
	localparam logic [7:0] SOURCES_RESET = 8'h00;

	// Divider: period is DIV_BASE shifted left by the code
	localparam int DIV_WIDTH = 9;
	localparam logic [9:0] DIV_BASE = 10'h004;
	localparam logic [9:0] DIV_ONE = 10'h001;
	localparam logic [8:0] DIV_ZERO = 9'h000;
	localparam logic [8:0] DIV_STEP = 9'h001;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

//--- hw/set_reset_latch_control.sv
// Notes on behaviour
// - Latch operates only while enable bit set
// - Pulse one clock wide every 4 shl code
// - True output pin driven when enabled
// - Inverted output pin driven when enabled
// - Enable low disables latch and both pins
// - Firmware set write gives one-cycle set
// - Firmware reset write gives one-cycle reset
// - Firmware pulse bits always read zero
// - Writing zero to pulse bits does nothing
// - All control bits clear on reset
// - Reset wins when set and reset coincide
// - Divider pulse sets or resets when enabled
// - Comparator high sets or resets when enabled
// - External pin sets or resets when enabled
module set_reset_latch_control (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic comp1_out,
	input wire logic comp2_out,
	input wire logic external_latch_input,
	output logic true_output_pin,
	output logic true_output_oe_b,
	output logic inverted_output_pin,
	output logic inverted_output_oe_b
);

	typedef struct packed {
		logic latch_enable;
		logic [2:0] pulse_divider_code;
		logic true_output_enable;
		logic inverted_output_enable;
		logic [7:0] sources;
		logic firmware_set_pulse;
		logic firmware_reset_pulse;
		logic [8:0] div_count;
		logic [2:0] active_code;
		logic clock_pulse;
		logic latch_q;
		logic dp_valid;
		logic dp_write;
		logic [11:0] dp_addr;
		logic [31:0] rdata;
	} state_t;

	state_t st;
	state_t next_st;

	// Last count value of one divider period
	function automatic logic [8:0] div_last(input logic [2:0] code);
		logic [9:0] period;
		period = 10'(latch_ctrl_pkg::DIV_BASE << code);
		return 9'(period - latch_ctrl_pkg::DIV_ONE);
	endfunction

	// Address match for a word register
	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] reg_addr);
		return a == reg_addr;
	endfunction

	logic addr_phase;
	logic dp_wr_primary;
	logic dp_wr_sources;
	logic set_in;
	logic reset_in;
	logic [7:0] primary_view;
	logic [7:0] sources_view;

	// Address phase accepted: non-sequential transfer of any size
	assign addr_phase = hsel && hready && (htrans == latch_ctrl_pkg::HTRANS_NONSEQ);
	assign dp_wr_primary = st.dp_valid && st.dp_write
		&& addr_is(st.dp_addr, latch_ctrl_pkg::ADDR_PRIMARY);
	assign dp_wr_sources = st.dp_valid && st.dp_write
		&& addr_is(st.dp_addr, latch_ctrl_pkg::ADDR_SOURCES);

	// Set and reset inputs gathered from every enabled source
	// Sources are levels: an enabled one acts every cycle it is high
	always_comb begin
		set_in = st.firmware_set_pulse
			|| (st.clock_pulse && st.sources[latch_ctrl_pkg::SRC_CLOCK_SET])
			|| (comp1_out && st.sources[latch_ctrl_pkg::SRC_COMP1_SET])
			|| (comp2_out && st.sources[latch_ctrl_pkg::SRC_COMP2_SET])
			|| (external_latch_input && st.sources[latch_ctrl_pkg::SRC_PIN_SET]);
		reset_in = st.firmware_reset_pulse
			|| (st.clock_pulse && st.sources[latch_ctrl_pkg::SRC_CLOCK_RESET])
			|| (comp1_out && st.sources[latch_ctrl_pkg::SRC_COMP1_RESET])
			|| (comp2_out && st.sources[latch_ctrl_pkg::SRC_COMP2_RESET])
			|| (external_latch_input && st.sources[latch_ctrl_pkg::SRC_PIN_RESET]);
	end

	// Next state of the whole block
	always_comb begin
		next_st = st;
		primary_view = 8'h00;
		sources_view = 8'h00;

		// pulse bits stand one cycle only
		next_st.firmware_set_pulse = 1'b0;
		next_st.firmware_reset_pulse = 1'b0;

		// Data phase of a write; only whole words land
		if (dp_wr_primary) begin
			next_st.latch_enable = hwdata[latch_ctrl_pkg::PRI_ENABLE];
			next_st.pulse_divider_code = hwdata[latch_ctrl_pkg::PRI_CODE_LSB +: 3];
			next_st.true_output_enable = hwdata[latch_ctrl_pkg::PRI_TRUE_OE];
			next_st.inverted_output_enable = hwdata[latch_ctrl_pkg::PRI_INV_OE];
			// a zero written leaves the input alone
			next_st.firmware_set_pulse = hwdata[latch_ctrl_pkg::PRI_FW_SET];
			// reset pulse from a written one
			next_st.firmware_reset_pulse = hwdata[latch_ctrl_pkg::PRI_FW_RESET];
		end
		if (dp_wr_sources) begin
			next_st.sources = hwdata[7:0];
		end

		// Code taken only at wrap, so no period is cut short
		// free-running count, code taken at wrap
		if (st.div_count == div_last(st.active_code)) begin
			next_st.div_count = latch_ctrl_pkg::DIV_ZERO;
			next_st.active_code = st.pulse_divider_code;
		end else begin
			next_st.div_count = 9'(st.div_count + latch_ctrl_pkg::DIV_STEP);
		end
		next_st.clock_pulse = (st.div_count == div_last(st.active_code));

		// Disabled latch keeps its value; only reset clears it
		// latch only moves while enabled
		if (st.latch_enable) begin
			if (reset_in) begin
				next_st.latch_q = 1'b0;
			end else if (set_in) begin
				next_st.latch_q = 1'b1;
			end
		end

		// Address phase bookkeeping
		next_st.dp_valid = addr_phase;
		next_st.dp_write = addr_phase && hwrite && (hsize == latch_ctrl_pkg::HSIZE_WORD);
		next_st.dp_addr = haddr[11:0];

		// Read views built from values after any write now landing
		// pulse bits always read zero
		primary_view[latch_ctrl_pkg::PRI_ENABLE] = next_st.latch_enable;
		primary_view[latch_ctrl_pkg::PRI_CODE_LSB +: 3] = next_st.pulse_divider_code;
		primary_view[latch_ctrl_pkg::PRI_TRUE_OE] = next_st.true_output_enable;
		primary_view[latch_ctrl_pkg::PRI_INV_OE] = next_st.inverted_output_enable;
		sources_view = next_st.sources;

		// Read data for the coming data phase; unmapped reads zero
		next_st.rdata = latch_ctrl_pkg::RDATA_ZERO;
		if (addr_phase && !hwrite) begin
			if (addr_is(haddr[11:0], latch_ctrl_pkg::ADDR_PRIMARY)) begin
				next_st.rdata = {24'h000000, primary_view};
			end else if (addr_is(haddr[11:0], latch_ctrl_pkg::ADDR_SOURCES)) begin
				next_st.rdata = {24'h000000, sources_view};
			end
		end
	end

	// State register
	// Latch state clears too, so the pins start known
	// every bit cleared on reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Bus answers: zero wait states, always OKAY
	// The master never sees a stall from this slave
	assign hreadyout = 1'b1;
	assign hresp = latch_ctrl_pkg::HRESP_OKAY;
	assign hrdata = st.rdata;

	// Output enables gate only the drivers; the latch runs behind them
	// true output onto its pin
	assign true_output_pin = st.latch_q;
	assign true_output_oe_b = !(st.latch_enable && st.true_output_enable);
	assign inverted_output_pin = !st.latch_q;
	assign inverted_output_oe_b = !(st.latch_enable && st.inverted_output_enable);

	// Helper: cycles since the last divider pulse
	logic [9:0] gap;
	logic [9:0] exp_gap;
	logic gap_seen;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gap <= 10'h000;
			exp_gap <= 10'h000;
			gap_seen <= 1'b0;
		end else if (st.clock_pulse) begin
			gap <= 10'h000;
			// Expected gap straight from the base and the code
			exp_gap <= 10'((latch_ctrl_pkg::DIV_BASE << st.active_code)
				- latch_ctrl_pkg::DIV_ONE);
			gap_seen <= 1'b1;
		end else begin
			gap <= 10'(gap + 10'h001);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// Latch behaviour checks
	a_reset_dominant: assert property (
		st.latch_enable && set_in && reset_in |=> !st.latch_q)
		else $error("set won over reset");
	a_comp_set: assert property (
		st.latch_enable && comp1_out && st.sources[latch_ctrl_pkg::SRC_COMP1_SET]
		&& !reset_in |=> st.latch_q)
		else $error("comparator did not set latch");
	a_pin_reset: assert property (
		st.latch_enable && external_latch_input
		&& st.sources[latch_ctrl_pkg::SRC_PIN_RESET] |=> !st.latch_q)
		else $error("external pin did not reset latch");
	a_clock_set: assert property (
		st.latch_enable && st.clock_pulse && st.sources[latch_ctrl_pkg::SRC_CLOCK_SET]
		&& !reset_in |=> st.latch_q)
		else $error("divider pulse did not set latch");
	a_hold_disabled: assert property (
		!st.latch_enable |=> st.latch_q == $past(st.latch_q))
		else $error("disabled latch changed");
	a_hold_idle: assert property (
		st.latch_enable && !set_in && !reset_in |=> st.latch_q == $past(st.latch_q))
		else $error("idle latch changed");
	a_pin_set: assert property (
		st.latch_enable && external_latch_input && st.sources[latch_ctrl_pkg::SRC_PIN_SET]
		&& !reset_in |=> st.latch_q)
		else $error("external pin did not set latch");
	a_comp2_reset: assert property (
		st.latch_enable && comp2_out
		&& st.sources[latch_ctrl_pkg::SRC_COMP2_RESET] |=> !st.latch_q)
		else $error("comparator did not reset latch");
	a_clock_reset: assert property (
		st.latch_enable && st.clock_pulse
		&& st.sources[latch_ctrl_pkg::SRC_CLOCK_RESET] |=> !st.latch_q)
		else $error("divider pulse did not reset latch");

	// Output pin checks
	a_pins_disabled: assert property (
		!st.latch_enable |-> true_output_oe_b && inverted_output_oe_b)
		else $error("pin driven while latch disabled");
	a_true_pin_on: assert property (
		st.latch_enable && st.true_output_enable
		|-> !true_output_oe_b && (true_output_pin == st.latch_q))
		else $error("true output not on pin");
	a_inv_pin_on: assert property (
		st.latch_enable && st.inverted_output_enable
		|-> !inverted_output_oe_b && (inverted_output_pin != st.latch_q))
		else $error("inverted output not on pin");
	a_true_pin_off: assert property (
		!st.true_output_enable |-> true_output_oe_b)
		else $error("true pin driven while its enable is off");
	a_inv_pin_off: assert property (
		!st.inverted_output_enable |-> inverted_output_oe_b)
		else $error("inverted pin driven while its enable is off");

	// Firmware pulse checks
	a_fw_set_pulse: assert property (
		dp_wr_primary && hwdata[latch_ctrl_pkg::PRI_FW_SET]
		|=> st.firmware_set_pulse ##1 (!st.firmware_set_pulse || $past(dp_wr_primary)))
		else $error("firmware set pulse wrong length");
	a_fw_reset_pulse: assert property (
		dp_wr_primary && hwdata[latch_ctrl_pkg::PRI_FW_RESET] |=> st.firmware_reset_pulse)
		else $error("firmware reset pulse missing");
	a_fw_zero_write: assert property (
		!(dp_wr_primary && hwdata[latch_ctrl_pkg::PRI_FW_SET]) |=> !st.firmware_set_pulse)
		else $error("set pulse without a written one");
	a_fw_read_zero: assert property (
		$past(addr_phase && !hwrite && addr_is(haddr[11:0], latch_ctrl_pkg::ADDR_PRIMARY))
		|-> hrdata[latch_ctrl_pkg::PRI_FW_SET] == 1'b0
		&& hrdata[latch_ctrl_pkg::PRI_FW_RESET] == 1'b0)
		else $error("pulse bit read back as one");
	a_fw_set_once: assert property (
		st.firmware_set_pulse |=> !st.firmware_set_pulse
		|| $past(dp_wr_primary && hwdata[latch_ctrl_pkg::PRI_FW_SET]))
		else $error("firmware set pulse stuck");
	a_fw_reset_once: assert property (
		st.firmware_reset_pulse |=> !st.firmware_reset_pulse
		|| $past(dp_wr_primary && hwdata[latch_ctrl_pkg::PRI_FW_RESET]))
		else $error("firmware reset pulse stuck");

	// Register write and read-back checks
	a_read_primary: assert property (
		$past(addr_phase && !hwrite && addr_is(haddr[11:0], latch_ctrl_pkg::ADDR_PRIMARY))
		|-> hrdata[latch_ctrl_pkg::PRI_ENABLE] == st.latch_enable
		&& hrdata[latch_ctrl_pkg::PRI_TRUE_OE] == st.true_output_enable)
		else $error("primary read data wrong");
	a_unmapped_zero: assert property (
		$past(addr_phase && !hwrite && !addr_is(haddr[11:0], latch_ctrl_pkg::ADDR_PRIMARY)
		&& !addr_is(haddr[11:0], latch_ctrl_pkg::ADDR_SOURCES))
		|-> hrdata == latch_ctrl_pkg::RDATA_ZERO)
		else $error("unmapped read not zero");
	a_read_high_zero: assert property (
		hrdata[31:latch_ctrl_pkg::PRI_ENABLE + 1] == '0)
		else $error("read data above the register not zero");
	a_primary_write: assert property (
		dp_wr_primary |=> st.latch_enable == $past(hwdata[latch_ctrl_pkg::PRI_ENABLE])
		&& st.pulse_divider_code == $past(hwdata[latch_ctrl_pkg::PRI_CODE_LSB +: 3]))
		else $error("primary write did not land");
	a_sources_write: assert property (
		dp_wr_sources |=> st.sources == $past(hwdata[7:0]))
		else $error("source enables write did not land");

	// Divider checks
	a_div_period: assert property (
		st.clock_pulse && gap_seen |-> gap == exp_gap)
		else $error("divider period wrong");
	a_div_wrap: assert property (
		st.clock_pulse |-> st.div_count == latch_ctrl_pkg::DIV_ZERO
		&& st.active_code == $past(st.pulse_divider_code))
		else $error("code not taken at wrap");
	a_pulse_width: assert property (
		st.clock_pulse |=> !st.clock_pulse)
		else $error("divider pulse wider than one clock");
	a_count_bound: assert property (
		st.div_count <= div_last(st.active_code))
		else $error("divider count beyond its period");

	// Main scenarios
	c_fw_set: cover property (dp_wr_primary && hwdata[latch_ctrl_pkg::PRI_FW_SET]
		##1 st.latch_enable ##1 st.latch_q);
	c_clock_toggle: cover property (st.latch_enable && st.clock_pulse && !st.latch_q
		##1 st.latch_q);
	c_slow_period: cover property (st.clock_pulse && st.active_code == 3'h7);
	c_both_inputs: cover property (st.latch_enable && set_in && reset_in);
	c_pin_reset: cover property (st.latch_enable && external_latch_input
		&& st.sources[latch_ctrl_pkg::SRC_PIN_RESET]);

endmodule

//--- dv/set_reset_latch_control_test.sv
module set_reset_latch_control_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, rst_b, hsel, hwrite, hreadyout, hresp;
	logic comp1_out, comp2_out, external_latch_input;
	logic true_output_pin, true_output_oe_b, inverted_output_pin, inverted_output_oe_b;
	logic [31:0] haddr, hwdata, hrdata, rd_s, seen;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic rdy_s;
	logic [11:0] tbl [7];
	int n_mismatch, cmp_count, cyc, k;

	set_reset_latch_control set_reset_latch_control_i (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.comp1_out(comp1_out), .comp2_out(comp2_out), .external_latch_input(external_latch_input),
		.true_output_pin(true_output_pin), .true_output_oe_b(true_output_oe_b),
		.inverted_output_pin(inverted_output_pin), .inverted_output_oe_b(inverted_output_oe_b));

	// Clock at 25 MHz
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Bus answer sampled mid-cycle, used at the next rising edge
	always @(negedge mclk) begin
		rd_s = hrdata;
		rdy_s = hreadyout;
	end

	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One AHB-Lite single word transfer
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= latch_ctrl_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= latch_ctrl_pkg::HSIZE_WORD;
		@(posedge mclk);
		while (rdy_s !== 1'b1) @(posedge mclk);
		htrans <= latch_ctrl_pkg::HTRANS_IDLE;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge mclk);
		while (rdy_s !== 1'b1) @(posedge mclk);
		seen = rd_s;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk("read data", seen, exp);
		chk("response", hresp, latch_ctrl_pkg::HRESP_OKAY);
	endtask

	// Settle, then check the pins
	task automatic pins(input logic q, input logic oq_b, input logic on_b);
		repeat (3) @(negedge mclk);
		chk("true pin", true_output_pin, q);
		chk("inverted pin", inverted_output_pin, !q);
		chk("true oe_b", true_output_oe_b, oq_b);
		chk("inverted oe_b", inverted_output_oe_b, on_b);
	endtask

	initial begin
		{rst_b, hsel, hwrite, comp1_out, comp2_out, external_latch_input} <= 6'h00;
		{haddr, hwdata, htrans, hsize} <= '0;
		// Source enables, inputs {c1,c2,pin}, expected Q
		tbl[0] = {8'h80, 3'h1, 1'b1};
		tbl[1] = {8'h08, 3'h1, 1'b0};
		tbl[2] = {8'h20, 3'h2, 1'b1};
		tbl[3] = {8'h02, 3'h2, 1'b0};
		tbl[4] = {8'h10, 3'h4, 1'b1};
		tbl[5] = {8'h00, 3'h7, 1'b1};
		tbl[6] = {8'h01, 3'h4, 1'b0};
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		rd(latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_0000);
		rd(latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_0000);
		pins(1'b0, 1'b1, 1'b1);
		bus(1'b1, latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_00A5);
		rd(latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_00A5);
		bus(1'b1, latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_0000);
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_008E);
		rd(latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_008C);
		pins(1'b1, 1'b0, 1'b0);
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_008C);
		pins(1'b1, 1'b0, 1'b0);
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_008D);
		pins(1'b0, 1'b0, 1'b0);
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_008A);
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_008B);
		pins(1'b0, 1'b0, 1'b1);
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_000E);
		pins(1'b0, 1'b1, 1'b1);
		bus(1'b1, 32'h0000_0008, 32'h0000_00FF);
		rd(32'h0000_0008, 32'h0000_0000);
		rd(latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_000C);
		// Pin and comparator sources in turn: enables, inputs {c1,c2,pin}, then Q
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_0080);
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, latch_ctrl_pkg::ADDR_SOURCES, {24'h000000, tbl[i][11:4]});
			@(posedge mclk);
			{comp1_out, comp2_out, external_latch_input} <= tbl[i][3:1];
			pins(tbl[i][0], 1'b1, 1'b1);
			@(posedge mclk);
			{comp1_out, comp2_out, external_latch_input} <= 3'h0;
		end
		// Comparator sets every cycle, divider pulse resets: Q low once a period
		bus(1'b1, latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_0014);
		comp1_out <= 1'b1;
		for (int code = 0; code < 8; code++) begin
			bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_0080 | (code << 4));
			repeat (2) begin
				@(negedge mclk);
				while (true_output_pin !== 1'b0) @(negedge mclk);
				@(negedge mclk);
			end
			k = 1;
			while (true_output_pin !== 1'b0) begin
				k++;
				@(negedge mclk);
			end
			chk("divider period", k, 32'h0000_0004 << code);
		end
		// Comparator reset holds Q low, then the divider alone sets it
		bus(1'b1, latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_0080);
		bus(1'b1, latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_0001);
		pins(1'b0, 1'b1, 1'b1);
		bus(1'b1, latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_0040);
		repeat (520) @(posedge mclk);
		pins(1'b1, 1'b1, 1'b1);
		// Second reset in mid-run clears everything again
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		comp1_out <= 1'b0;
		pins(1'b0, 1'b1, 1'b1);
		rd(latch_ctrl_pkg::ADDR_PRIMARY, 32'h0000_0000);
		rd(latch_ctrl_pkg::ADDR_SOURCES, 32'h0000_0000);
		close_out();
	end
endmodule
